//--- acpr_pkg.sv
/*
  acpr_pkg: constants for the power-loss recovery block (offsets, fields,
  reset values, timing, state codes).
  assumes a 40 MHz system clock and an APB bus with 32-bit data.
*/
package acpr_pkg;

  // apb byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_HIST = 12'h004;

  // control register fields
  localparam int BIT_BTN_EN = 0;
  localparam int BIT_REC_EN = 2;
  localparam int BIT_MODE2  = 3;
  localparam int BIT_PREV   = 4;
  localparam int POL_LO     = 5;
  localparam int POL_HI     = 6;
  localparam int BIT_LOCK   = 7;

  // masks and reset values
  localparam logic [7:0] WR_MASK     = 8'hEF;
  localparam logic [7:0] VBAT_CLR    = 8'h7C;
  localparam logic [7:0] STBY_SET    = 8'h03;
  localparam logic [7:0] CTRL_RST    = 8'h03;
  localparam logic [7:0] HIST_RST    = 8'h00;
  localparam logic [4:0] PIN_INIT    = 5'h1C;

  // recovery policy codes
  localparam logic [1:0] POL_OFF  = 2'h0;
  localparam logic [1:0] POL_ON   = 2'h1;
  localparam logic [1:0] POL_PREV = 2'h2;

  // timing
  localparam int unsigned CLK_HZ     = 40000000;
  localparam int unsigned SAMPLE_MS  = 500;
  localparam int unsigned PULSE_MS   = 100;
  localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1000) * SAMPLE_MS;
  localparam int unsigned PULSE_CYC  = (CLK_HZ / 1000) * PULSE_MS;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_DOWN  = 4'h1,
    ST_EVAL  = 4'h2,
    ST_PULSE = 4'h4,
    ST_UP    = 4'h8
  } acpr_state_t;

endpackage : acpr_pkg

//--- acpr_top.sv
/*
  acpr_top: ac power loss recovery with control register, supply-on
  sample history and power-button pulse generation, behind an APB slave.
  assumes rail reset pins are asynchronous; clk_sys keeps running while
  standby power is absent.
*/
// The register addresses and the APB interface to the registers were left to the implementer.
// Functional notes
// RL1 - control bit 0 enables the power button function, default enabled.
// RL2 - bit 2 enables automatic power failure recovery, default disabled.
// RL3 - bit 3 clear is mode 1 without sampling, set is mode 2 sampling.
// RL4 - mode 2 samples supply-on every half second into eight-bit history.
// RL5 - bit 4 holds supply-on state at standby loss; read-only, battery kept.
// RL6 - previous-state 0 means supply was off, pin was high.
// RL7 - register writable while lock bit 7 clear; bit 4 never writable.
// RL8 - standby power-up evaluates recovery policy bits.
// RL9 - a decision of on emits a power-button pulse.
// RL10 - supply-on pin only follows chipset sleep-state input, never recovery.
// RL11 - policy code 00 leaves supply off, no pulse.
// RL12 - standby power-up loads bits 1:0 with 11 and clears lock.
// RL13 - battery reset clears bits 6 to 2 only.
// RL14 - main rail or bus reset clears only the lock bit; rstn reloads the whole register with 03 instead.
// RL15 - history bit 0 newest sample, bit 7 oldest, 1 means pin low.
// RL16 - history cleared by battery reset, kept across standby reset.
// RL17 - button pulse is active low, fixed length, once per power-up.
// RL18 - standby loss stops sampling and freezes the history.
`timescale 1ns/1ps
module acpr_top #(
  parameter int unsigned SAMPLE_CYCLES = acpr_pkg::SAMPLE_CYC,
  parameter int unsigned PULSE_CYCLES  = acpr_pkg::PULSE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        standby_power_good,
  input  wire logic        battery_por,
  input  wire logic        main_rst_n,
  input  wire logic        chipset_sleep_state_n,
  input  wire logic        power_button_in_n,
  output logic             supply_on_n,
  output logic             button_pulse_out_n
);

  logic [1:0]            rstPipe_r;
  wire                   rstSyncN;
  wire  [4:0]            pinRaw;
  wire  [4:0]            pinSync;
  logic                  standbyPrev_r;
  logic [7:0]            ctrl_r;
  logic [7:0]            ctrlNxt;
  logic [7:0]            hist_r;
  logic [7:0]            histNxt;
  logic [31:0]           tickCnt_r;
  logic [31:0]           pulseCnt_r;
  acpr_pkg::acpr_state_t state_r;
  acpr_pkg::acpr_state_t stateNxt;
  logic                  policyOn;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstPipe_r <= 2'h0;
    else
      rstPipe_r <= {rstPipe_r[0], 1'b1};
  end
  assign rstSyncN = rstPipe_r[1];

  // pin synchronisers, two flops each
  assign pinRaw = {power_button_in_n, chipset_sleep_state_n, main_rst_n,
                   battery_por, standby_power_good};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk_sys or negedge rstSyncN)
      begin
        if (!rstSyncN)
        begin
          meta_r <= acpr_pkg::PIN_INIT[gi];
          sync_r <= acpr_pkg::PIN_INIT[gi];
        end
        else
        begin
          meta_r <= pinRaw[gi];
          sync_r <= meta_r;
        end
      end
      assign pinSync[gi] = sync_r;
    end
  endgenerate

  // rail events
  wire standbyUp   = pinSync[0];
  wire vbatPor     = pinSync[1];
  wire mainRst     = ~pinSync[2];
  wire sleepN      = pinSync[3];
  wire btnInN      = pinSync[4];
  wire standbyRise = standbyUp & ~standbyPrev_r;
  wire standbyFall = ~standbyUp & standbyPrev_r;

  // apb decode
  wire apbAccess = psel & penable;
  wire apbFirst  = apbAccess & ~pready;
  wire apbDone   = apbAccess & pready;
  wire hitCtrl   = paddr == acpr_pkg::ADDR_CTRL;
  wire hitHist   = paddr == acpr_pkg::ADDR_HIST;
  wire mapped    = hitCtrl | hitHist;
  wire locked    = ctrl_r[acpr_pkg::BIT_LOCK];
  wire ctrlWrite = apbDone & pwrite & hitCtrl & pstrb[0] & ~locked; // [RL7]
  wire [31:0] rdMux = hitCtrl ? {24'h0, ctrl_r} :
                      hitHist ? {24'h0, hist_r} : 32'h0;

  // apb answer, one wait state
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= apbFirst;
      pslverr <= apbFirst & ~mapped;
      prdata  <= (apbFirst & ~pwrite) ? rdMux : 32'h0;
    end
  end

  // control register next value; rail events override a write
  always_comb
  begin
    ctrlNxt = ctrl_r;
    if (ctrlWrite)
      ctrlNxt = (ctrl_r & ~acpr_pkg::WR_MASK) | (pwdata[7:0] & acpr_pkg::WR_MASK); // [RL7]
    if (standbyFall)
      ctrlNxt[acpr_pkg::BIT_PREV] = ~supply_on_n; // [RL5] [RL6]
    if (vbatPor)
      ctrlNxt = ctrlNxt & ~acpr_pkg::VBAT_CLR; // [RL13]
    if (standbyRise)
    begin
      ctrlNxt = ctrlNxt | acpr_pkg::STBY_SET; // [RL12]
      ctrlNxt[acpr_pkg::BIT_LOCK] = 1'b0;
    end
    if (mainRst)
      ctrlNxt[acpr_pkg::BIT_LOCK] = 1'b0; // [RL14]
  end

  // half-second sampling tick, runs only with standby up in mode 2
  wire mode2     = ctrl_r[acpr_pkg::BIT_MODE2];
  wire sampleRun = standbyUp & mode2; // [RL3] [RL18]
  wire tick      = sampleRun & (tickCnt_r == SAMPLE_CYCLES - 1); // [RL4]

  // history shift, newest into bit 0
  always_comb
  begin
    histNxt = hist_r;
    if (vbatPor)
      histNxt = acpr_pkg::HIST_RST; // [RL16]
    else if (tick)
      histNxt = {hist_r[6:0], ~supply_on_n}; // [RL4] [RL15]
  end

  // recovery policy decision
  wire [1:0] policy = ctrl_r[acpr_pkg::POL_HI:acpr_pkg::POL_LO];
  wire       prevOn = mode2 ? hist_r[0] : ctrl_r[acpr_pkg::BIT_PREV];
  always_comb
  begin
    case (policy)
      acpr_pkg::POL_OFF:  policyOn = 1'b0; // [RL11]
      acpr_pkg::POL_ON:   policyOn = 1'b1;
      acpr_pkg::POL_PREV: policyOn = prevOn;
      default:            policyOn = 1'b0;
    endcase
  end
  wire wantOn  = ctrl_r[acpr_pkg::BIT_REC_EN] & policyOn; // [RL2] [RL8]
  wire pulseEnd = pulseCnt_r == PULSE_CYCLES - 1;

  // sequencer: one evaluation and at most one pulse per power-up
  always_comb
  begin
    stateNxt = state_r;
    case (state_r)
      acpr_pkg::ST_DOWN:
        if (standbyRise)
          stateNxt = acpr_pkg::ST_EVAL; // [RL8]
      acpr_pkg::ST_EVAL:
        stateNxt = wantOn ? acpr_pkg::ST_PULSE : acpr_pkg::ST_UP; // [RL9]
      acpr_pkg::ST_PULSE:
        if (pulseEnd)
          stateNxt = acpr_pkg::ST_UP; // [RL17]
      acpr_pkg::ST_UP:
        stateNxt = acpr_pkg::ST_UP;
      default:
        stateNxt = acpr_pkg::ST_DOWN;
    endcase
    if (!standbyUp)
      stateNxt = acpr_pkg::ST_DOWN;
  end

  // button output: recovery pulse or gated pass-through of the button
  wire inPulse = state_r == acpr_pkg::ST_PULSE;
  wire btnPass = ctrl_r[acpr_pkg::BIT_BTN_EN] & ~btnInN & standbyUp; // [RL1]

  // state, counters and registers
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_r       <= acpr_pkg::ST_DOWN;
      standbyPrev_r <= 1'b0;
      ctrl_r        <= acpr_pkg::CTRL_RST;
      hist_r        <= acpr_pkg::HIST_RST;
      tickCnt_r     <= 32'h0;
      pulseCnt_r    <= 32'h0;
    end
    else
    begin
      state_r       <= stateNxt;
      standbyPrev_r <= standbyUp;
      ctrl_r        <= ctrlNxt;
      hist_r        <= histNxt;
      tickCnt_r     <= (sampleRun & ~tick) ? tickCnt_r + 32'h1 : 32'h0;
      pulseCnt_r    <= inPulse ? pulseCnt_r + 32'h1 : 32'h0;
    end
  end

  // pin outputs
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      supply_on_n        <= 1'b1;
      button_pulse_out_n <= 1'b1;
    end
    else
    begin
      supply_on_n        <= sleepN; // [RL10]
      button_pulse_out_n <= ~(inPulse | btnPass); // [RL17]
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstSyncN);

  a_lock_blocks_write: assert property ( // [RL7]
    apbDone && pwrite && hitCtrl && locked && !standbyRise && !mainRst
    && !vbatPor && !standbyFall |=> $stable(ctrl_r))
    else $error("locked register changed on write");

  a_prev_read_only: assert property ( // [RL5]
    !standbyFall && !vbatPor |=> $stable(ctrl_r[acpr_pkg::BIT_PREV]))
    else $error("previous-state bit changed without rail event");

  a_standby_defaults: assert property ( // [RL12]
    standbyRise |=> ctrl_r[1:0] == 2'h3 && !ctrl_r[acpr_pkg::BIT_LOCK])
    else $error("standby power-up defaults not loaded");

  a_vbat_clears: assert property ( // [RL13]
    vbatPor && !standbyRise && !mainRst && !ctrlWrite
    |=> ctrl_r[6:2] == 5'h0 && hist_r == 8'h0
        && ctrl_r[7] == $past(ctrl_r[7]))
    else $error("battery reset clear wrong");

  a_main_unlock: assert property ( // [RL14]
    mainRst && !vbatPor && !standbyRise && !ctrlWrite && !standbyFall
    |=> !ctrl_r[7] && ctrl_r[6:0] == $past(ctrl_r[6:0]))
    else $error("main reset touched more than lock");

  a_policy_off: assert property ( // [RL11]
    state_r == acpr_pkg::ST_EVAL && policy == acpr_pkg::POL_OFF
    |=> state_r != acpr_pkg::ST_PULSE)
    else $error("pulse with policy off");

  a_eval_pulse: assert property ( // [RL9]
    state_r == acpr_pkg::ST_EVAL && wantOn && standbyUp
    |=> inPulse ##1 !button_pulse_out_n)
    else $error("decision on gave no pulse");

  a_pulse_bound: assert property ( // [RL17]
    inPulse |-> pulseCnt_r < PULSE_CYCLES)
    else $error("button pulse too long");

  a_supply_follow: assert property ( // [RL10]
    ##1 supply_on_n == $past(sleepN))
    else $error("supply-on not following sleep input");

  a_hist_shift: assert property ( // [RL4]
    tick && !vbatPor |=> hist_r == {$past(hist_r[6:0]), ~$past(supply_on_n)})
    else $error("history shift wrong");

  a_hist_freeze: assert property ( // [RL18]
    (!standbyUp || !mode2) && !vbatPor |=> $stable(hist_r))
    else $error("history moved while frozen");

  c_recovery_pulse: cover property (state_r == acpr_pkg::ST_EVAL ##1 inPulse);
  c_locked_write:   cover property (apbDone && pwrite && hitCtrl && locked);
  c_power_loss:     cover property (standbyFall && mode2);
  c_sample_tick:    cover property (tick);

endmodule : acpr_top

//--- acpr_chipset_model.sv
/*
  acpr_chipset_model: chipset sleep-state source on the far side.
  assumes the bench asks for sleep or wake with one-cycle pulses.
*/
`timescale 1ns/1ps
module acpr_chipset_model (
  input  wire logic       clk_sys,
  input  wire logic       button_pulse_out_n,
  input  wire logic       sleepReq,
  input  wire logic       wakeReq,
  input  wire logic [3:0] wakeDelay,
  output logic            chipset_sleep_state_n
);
  int   cnt   = 0;
  logic awake = 1'b0;

  // a button pulse wakes the chipset after a variable delay
  always @(posedge clk_sys)
  begin
    if (sleepReq)
    begin
      awake <= 1'b0;
      cnt <= 0;
    end
    else if (wakeReq)
      awake <= 1'b1;
    else if (cnt == 1)
    begin
      awake <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (!button_pulse_out_n && !awake)
      cnt <= wakeDelay + 1;
  end

  // chipset alone drives the sleep-state line
  assign chipset_sleep_state_n = ~awake;
endmodule : acpr_chipset_model

//--- ac_power_loss_recovery_test.sv
/*
  ac_power_loss_recovery_test: self-checking bench for acpr_top.
  assumes short sample and pulse counts and the chipset model alongside.
*/
`timescale 1ns/1ps
module ac_power_loss_recovery_test;
  localparam int SAMPLE = 8;
  localparam int PULSE  = 4;
  logic        clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        standby_power_good = 1, battery_por = 0, main_rst_n = 1;
  logic        power_button_in_n = 1, sleepReq = 0, wakeReq = 0, errBit;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdData;
  logic [3:0]  pstrb = 4'hF, wakeDelay = 4'h1;
  logic        pready, pslverr, supply_on_n, button_pulse_out_n, chipset_sleep_state_n;
  int          failures = 0, n_tests = 0, ctrlM, lowCnt, prev, pol, expP, i;
  logic [7:0]  h;

  acpr_top #(
    .SAMPLE_CYCLES(SAMPLE),
    .PULSE_CYCLES (PULSE)
  ) i_dut (
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .standby_power_good   (standby_power_good),
    .battery_por          (battery_por),
    .main_rst_n           (main_rst_n),
    .chipset_sleep_state_n(chipset_sleep_state_n),
    .power_button_in_n    (power_button_in_n),
    .supply_on_n          (supply_on_n),
    .button_pulse_out_n   (button_pulse_out_n)
  );

  acpr_chipset_model i_chip (
    .clk_sys              (clk_sys),
    .button_pulse_out_n   (button_pulse_out_n),
    .sleepReq             (sleepReq),
    .wakeReq              (wakeReq),
    .wakeDelay            (wakeDelay),
    .chipset_sleep_state_n(chipset_sleep_state_n)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    rdData = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask : rdc

  // control write; the model keeps bit 4 and honours the lock
  task automatic wr(input logic [7:0] d);
    apb(1'b1, acpr_pkg::ADDR_CTRL, {24'h0, d});
    if (!ctrlM[7])
      ctrlM = (d & acpr_pkg::WR_MASK) | (ctrlM & 8'h10);
  endtask : wr

  task automatic chip(input logic wake);
    wakeReq <= wake;
    sleepReq <= !wake;
    cyc(1);
    wakeReq <= 1'b0;
    sleepReq <= 1'b0;
    cyc(6);
  endtask : chip

  // watchdog
  initial
  begin
    #500000;
    failures++;
    final_report();
  end

  // main sequence
  initial
  begin
    void'($urandom(46));
    cyc(10);
    rstn <= 1'b1;
    cyc(12);
    ctrlM = 8'h03;
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    rdc(acpr_pkg::ADDR_HIST, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({errBit, rdData[30:0]}, 32'h80000000);
    // write with byte strobe 0 low and history write are both ignored
    pstrb <= 4'h0;
    apb(1'b1, acpr_pkg::ADDR_CTRL, 32'hFF);
    pstrb <= 4'hF;
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    apb(1'b1, acpr_pkg::ADDR_HIST, 32'hFF);
    rdc(acpr_pkg::ADDR_HIST, 32'h0);
    wr(8'hFF);
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    wr(8'h00);
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    main_rst_n <= 1'b0;
    cyc(4);
    main_rst_n <= 1'b1;
    cyc(4);
    ctrlM[7] = 0;
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    battery_por <= 1'b1;
    cyc(4);
    battery_por <= 1'b0;
    cyc(4);
    ctrlM &= ~acpr_pkg::VBAT_CLR;
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    chip(1'b1);
    chk(supply_on_n, 1'b0);
    // button pass-through, then gated off
    power_button_in_n <= 1'b0;
    cyc(6);
    chk(button_pulse_out_n, 1'b0);
    power_button_in_n <= 1'b1;
    wr(8'h02);
    power_button_in_n <= 1'b0;
    cyc(6);
    chk(button_pulse_out_n, 1'b1);
    power_button_in_n <= 1'b1;
    // mode 2 history fill, newest sample at bit 0, freeze on loss
    wr(8'h0F);
    cyc(SAMPLE * 9 + 6);
    rdc(acpr_pkg::ADDR_HIST, 32'hFF);
    chip(1'b0);
    cyc(2 * SAMPLE);
    standby_power_good <= 1'b0;
    cyc(6);
    ctrlM[4] = 0;
    apb(1'b0, acpr_pkg::ADDR_HIST, 32'h0);
    h = rdData[7:0];
    chk(rdData & 32'h81, 32'h80);
    cyc(5 * SAMPLE);
    rdc(acpr_pkg::ADDR_HIST, {24'h0, h});
    rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    // power-up policy decisions with random previous state
    for (i = 0; i < 6; i++)
    begin
      prev = $urandom % 2;
      pol = i % 4;
      wakeDelay <= 4'($urandom % 8);
      standby_power_good <= 1'b1;
      chip(prev[0]);
      standby_power_good <= 1'b0;
      cyc(6);
      ctrlM[4] = prev[0];
      chip(1'b0);
      wr(8'h01 | ((i < 4) ? 8'h04 : 8'h00) | 8'(pol << 5));
      expP = (i < 4 && (pol == 1 || (pol == 2 && prev == 1))) ? PULSE : 0;
      standby_power_good <= 1'b1;
      lowCnt = 0;
      repeat (40)
      begin
        @(posedge clk_sys);
        if (button_pulse_out_n === 1'b0)
          lowCnt++;
      end
      chk(lowCnt, expP);
      chk(supply_on_n, (expP == 0));
      ctrlM = (ctrlM & 8'h7C) | 8'h03;
      rdc(acpr_pkg::ADDR_CTRL, ctrlM);
    end
    final_report();
  end
endmodule : ac_power_loss_recovery_test
